/* File: design/bbx_unit.sv */
// bit-band remapper, exclusive monitor and barrier drain, core side to system bus
// Summary of operation
// R1: bit-band covers only first 64 KB of sram and first megabyte of peripheral region, one bit per alias word
// R2: sram alias 0x2200_0000..0x221f_ffff maps to bits at 0x2000_0000
// R3: peripheral alias 0x4200_0000..0x43ff_ffff maps to bits of 0x4000_0000..0x400f_ffff
// R4: byte offset is alias offset/32, bit number is (offset mod 32)/4
// R5: alias write is read, change one bit, write back
// R6: instruction fetches in sram alias pass through unmapped
// R7: instruction fetches in peripheral alias are refused
// R8: underlying access keeps the original access size
// R9: alias write uses data bit 0 only, bits 31:1 ignored
// R10: alias read returns 1 if bit set, else 0, other bits zero
// R11: direct bit-band accesses behave as plain accesses
// R12: data is little-endian, lowest byte address holds least significant byte
// R13: exclusive load records a tag for the addressed location
// R14: exclusive store writes and returns 0 only with tag held, else 1, no write; here a store that faults on its address gets the fault with status 0
// R15: exclusive pairs exist for word, half and byte sizes
// R16: clear-exclusive drops the tag
// R17: every exclusive store drops the tag; here a store that faults on its address leaves the tag held
// R18: taking an exception drops the tag
// R19: software retries whole sequence after a failed exclusive store
// R20: memory barrier drains outstanding transactions before the next is issued
// R21: sync barrier drains outstanding transactions before next instruction runs
// R22: alias read and write-back are locked together on the bus
// R23: reserved address space answers with a bus fault
`timescale 1ns/10ps
`default_nettype none
module bbx_unit
  import bbx_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_fetch_i,
  input wire logic [1:0] req_size_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic req_load_excl_i,
  input wire logic req_store_excl_i,
  input wire logic clear_exclusive_tag_i,
  input wire logic data_memory_barrier_i,
  input wire logic data_sync_barrier_i,
  input wire logic exception_taken_i,
  input wire logic bus_done_i,
  input wire logic bus_err_i,
  input wire logic [DATA_W-1:0] bus_rdata_i,
  input wire logic bus_wr_posted_i,
  output logic req_ready_o,
  output logic resp_valid_o,
  output logic resp_fault_o,
  output logic resp_excl_fail_o,
  output logic [DATA_W-1:0] resp_rdata_o,
  output logic barrier_done_o,
  output logic exec_hold_o,
  output logic bus_valid_o,
  output logic bus_write_o,
  output logic bus_lock_o,
  output logic [1:0] bus_size_o,
  output logic [ADDR_W-1:0] bus_addr_o,
  output logic [DATA_W-1:0] bus_wdata_o
);
  typedef struct packed {
    bbx_state_t st;
    logic ready;
    logic rvalid;
    logic fault;
    logic xfail;
    logic [31:0] rdata;
    logic bdone;
    logic hold;
    logic bvalid;
    logic bwrite;
    logic block;
    logic [1:0] bsize;
    logic [31:0] baddr;
    logic [31:0] bwdata;
    logic [2:0] bitn;
    logic newbit;
    logic tag_ok;
    logic [31:0] tag_addr;
    logic pend_dmb;
    logic pend_dsb;
  } bbx_state_s_t;

  bbx_state_s_t s;
  bbx_state_s_t next_s;

  // window bounds and lane math assume a 32-bit map, so other widths are refused
  if (ADDR_W != 32) begin : g_addr_w_check
    $error("bbx_unit address width must be 32");
  end
  if (DATA_W != 32) begin : g_data_w_check
    $error("bbx_unit data width must be 32");
  end

  logic in_sram_alias;
  logic in_peri_alias;
  logic in_alias;
  logic mapped;
  logic [31:0] alias_off;
  logic [31:0] band_addr;
  logic [4:0] lane_bit;
  logic [31:0] cur_word;
  logic posted_open;
  logic in_flash;
  logic in_sram_band;
  logic in_peri_band;
  logic in_fabric;

  always_comb begin
    in_sram_alias = req_addr_i >= SRAM_ALIAS_BASE && req_addr_i <= SRAM_ALIAS_LAST; // [R2]
    in_peri_alias = req_addr_i >= PERI_ALIAS_BASE && req_addr_i <= PERI_ALIAS_LAST; // [R3]
    // only the low 64 KB of sram and low megabyte of peripherals are bit-banded, alias windows are 32x that [R1]
    in_alias = (in_sram_alias && !req_fetch_i) || in_peri_alias; // [R6]
    alias_off = in_sram_alias ? req_addr_i - SRAM_ALIAS_BASE : req_addr_i - PERI_ALIAS_BASE;
    band_addr = (in_sram_alias ? SRAM_BAND_BASE : PERI_BAND_BASE)
                + (alias_off >> ALIAS_WORD_SHIFT); // [R4]
    // reserved holes fault; other regions are left to the downstream fabric [R23]
    in_flash = req_addr_i <= FLASH_LAST;
    in_sram_band = req_addr_i >= SRAM_BAND_BASE && req_addr_i <= SRAM_BAND_LAST; // [R11]
    in_peri_band = req_addr_i >= PERI_BAND_BASE && req_addr_i <= PERI_BAND_LAST; // [R11]
    // above the peripheral alias the fabric answers, no fault is made here
    in_fabric = req_addr_i > PERI_ALIAS_LAST;

    mapped = in_flash || in_sram_band || in_sram_alias;
    mapped = mapped || in_peri_band || in_peri_alias || in_fabric;

    // target bit sits in byte lane given by low address bits, little-endian [R12]
    lane_bit = {s.baddr[1:0], s.bitn};
    cur_word = bus_rdata_i;
    posted_open = bus_wr_posted_i;
  end

  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.bdone = 1'b0;
    if (exception_taken_i || clear_exclusive_tag_i) begin
      next_s.tag_ok = 1'b0; // [R16] [R18]
    end
    // ready drops on the edge that samples the pulse unless a drain finishes in that cycle, so no later request slips in before the drain
    if (data_memory_barrier_i) begin
      next_s.pend_dmb = 1'b1;
      next_s.ready = 1'b0; // [R20]
    end
    if (data_sync_barrier_i) begin
      next_s.pend_dsb = 1'b1;
      next_s.ready = 1'b0; // [R20]
      next_s.hold = 1'b1; // [R21]
    end
    unique case (s.st)
      BBX_IDLE: begin
        if ((s.pend_dmb || s.pend_dsb) && !posted_open) begin
          // drain finished: release barriers before taking new traffic [R20] [R21]
          next_s.pend_dmb = 1'b0;
          next_s.pend_dsb = 1'b0;
          next_s.hold = 1'b0;
          next_s.bdone = 1'b1;
          next_s.ready = 1'b1;
        end else if (s.pend_dmb || s.pend_dsb) begin
          next_s.ready = 1'b0; // [R20]
        end else if (req_valid_i && s.ready) begin
          next_s.ready = 1'b0;
          next_s.fault = 1'b0;
          next_s.xfail = 1'b0;
          next_s.rdata = '0;
          next_s.bsize = req_size_i; // [R8]
          next_s.bitn = alias_off[ALIAS_BIT_LSB +: 3]; // [R4]
          next_s.newbit = req_wdata_i[0]; // [R9]
          if (!mapped || (in_peri_alias && req_fetch_i)) begin
            next_s.fault = 1'b1; // [R7] [R23]
            next_s.rvalid = 1'b1;
            next_s.st = BBX_RESP;
          // tag match is the full byte address; a mismatch never reaches the bus
          end else if (req_store_excl_i && !(s.tag_ok && s.tag_addr == req_addr_i)) begin
            next_s.xfail = 1'b1; // [R14]
            next_s.tag_ok = 1'b0; // [R17]
            next_s.rvalid = 1'b1;
            next_s.st = BBX_RESP;
          end else begin
            if (req_load_excl_i) begin
              next_s.tag_ok = 1'b1; // [R13] [R15]
              next_s.tag_addr = req_addr_i;
            end
            if (req_store_excl_i) begin
              next_s.tag_ok = 1'b0; // [R17]
            end
            next_s.bvalid = 1'b1;
            if (in_alias) begin
              next_s.baddr = band_addr;
              next_s.bwrite = 1'b0;
              next_s.block = req_write_i; // [R22]
              next_s.st = req_write_i ? BBX_RMW_RD : BBX_ALIAS_RD; // [R5]
            end else begin
              next_s.baddr = req_addr_i; // [R11]
              next_s.bwrite = req_write_i;
              next_s.bwdata = req_wdata_i;
              next_s.block = 1'b0;
              next_s.st = BBX_PASS;
            end
          end
        end
      end

      // one request in flight only; a second port would need arbitration here
      BBX_PASS: begin
        if (bus_done_i) begin
          next_s.bvalid = 1'b0;
          next_s.fault = bus_err_i;
          next_s.rdata = s.bwrite ? '0 : bus_rdata_i;
          next_s.rvalid = 1'b1;
          next_s.st = BBX_RESP;
        end
      end

      BBX_ALIAS_RD: begin
        if (bus_done_i) begin
          next_s.bvalid = 1'b0;
          next_s.fault = bus_err_i;
          next_s.rdata = cur_word[lane_bit] ? ALIAS_READ_SET : ALIAS_READ_CLR; // [R10]
          next_s.rvalid = 1'b1;
          next_s.st = BBX_RESP;
        end
      end

      // an error on the read half skips the write back and frees the lock
      BBX_RMW_RD: begin
        if (bus_done_i && bus_err_i) begin
          next_s.bvalid = 1'b0;
          next_s.block = 1'b0;
          next_s.fault = 1'b1;
          next_s.rvalid = 1'b1;
          next_s.st = BBX_RESP;
        end else if (bus_done_i) begin
          // lock held across both halves so nothing slips in between [R22]
          next_s.bwrite = 1'b1;
          next_s.bwdata = cur_word;
          next_s.bwdata[lane_bit] = s.newbit; // [R5] [R9]
          next_s.st = BBX_RMW_WR;
        end
      end

      BBX_RMW_WR: begin
        if (bus_done_i) begin
          next_s.bvalid = 1'b0;
          next_s.bwrite = 1'b0;
          next_s.block = 1'b0;
          next_s.fault = bus_err_i;
          next_s.rvalid = 1'b1;
          next_s.st = BBX_RESP;
        end
      end

      // ready comes back one cycle after the response pulse
      BBX_RESP: begin
        next_s.st = BBX_IDLE;
        next_s.ready = !(next_s.pend_dmb || next_s.pend_dsb);
      end

      // codes 6 and 7 are unused and fall back to idle
      default: begin
        next_s.st = BBX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // reset leaves the tag dropped and the port able to take a request
      s <= '0;
      s.ready <= 1'b1;
      s.st <= BBX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign req_ready_o = s.ready;
  assign resp_valid_o = s.rvalid;
  assign resp_fault_o = s.fault;
  assign resp_excl_fail_o = s.xfail;
  assign resp_rdata_o = s.rdata;
  assign barrier_done_o = s.bdone;
  assign exec_hold_o = s.hold;
  assign bus_valid_o = s.bvalid;
  assign bus_write_o = s.bwrite;
  assign bus_lock_o = s.block;
  assign bus_size_o = s.bsize;
  assign bus_addr_o = s.baddr;
  assign bus_wdata_o = s.bwdata;
endmodule
`default_nettype wire

/* File: design/bbx_pkg.sv */
// package for the bit-band and exclusive access front end
package bbx_pkg;
  localparam logic [31:0] SRAM_BAND_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM_BAND_LAST = 32'h2000_ffff;
  localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] SRAM_ALIAS_LAST = 32'h221f_ffff;
  localparam logic [31:0] PERI_BAND_BASE = 32'h4000_0000;
  localparam logic [31:0] PERI_BAND_LAST = 32'h400f_ffff;
  localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
  localparam logic [31:0] PERI_ALIAS_LAST = 32'h43ff_ffff;
  localparam logic [31:0] FLASH_LAST = 32'h0001_7fff;
  localparam int ALIAS_WORD_SHIFT = 5;
  localparam int ALIAS_BIT_LSB = 2;
  localparam logic [31:0] ALIAS_READ_SET = 32'h0000_0001;
  localparam logic [31:0] ALIAS_READ_CLR = 32'h0000_0000;
  typedef enum logic [1:0] {
    BBX_SZ_BYTE = 2'h0,
    BBX_SZ_HALF = 2'h1,
    BBX_SZ_WORD = 2'h2
  } bbx_size_t;
  typedef enum logic [2:0] {
    BBX_IDLE = 3'h0,
    BBX_PASS = 3'h1,
    BBX_RMW_RD = 3'h2,
    BBX_RMW_WR = 3'h3,
    BBX_ALIAS_RD = 3'h4,
    BBX_RESP = 3'h5
  } bbx_state_t;
endpackage

/* File: testbench/bbx_bus_model.sv */
// system bus memory model answering the block's bus beats
`timescale 1ns/10ps
`default_nettype none
module bbx_bus_model (
  input wire logic clk_i,
  input wire logic valid_i, write_i, slow_i,
  input wire logic [31:0] addr_i, wdata_i,
  output logic done_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [logic [29:0]];
  logic [31:0] w;
  int n = 0;
  initial begin
    done_o = 1'b0;
    rdata_o = 32'h0;
  end
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    // read data is not held once the beat is over
    rdata_o <= ~rdata_o;
    if (valid_i && !done_o) begin
      // fresh words read as their inverted address, so a remap shows
      w = mem.exists(addr_i[31:2]) ? mem[addr_i[31:2]] : ~{addr_i[31:2], 2'b00};
      if (n < (slow_i ? 3 : 0)) begin
        n <= n + 1;
      end else begin
        n <= 0;
        done_o <= 1'b1;
        rdata_o <= w;
        if (write_i) mem[addr_i[31:2]] = wdata_i;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/bbx_unit_monitor.sv */
// concurrent checks on the bit-band and exclusive access unit ports
`timescale 1ns/10ps
`default_nettype none
module bbx_unit_monitor
  import bbx_pkg::*;
(
  input wire logic clk_i, arst_n_i, req_valid_i, req_write_i, req_fetch_i,
  input wire logic [1:0] req_size_i,
  input wire logic [31:0] req_addr_i,
  input wire logic req_load_excl_i, req_store_excl_i, clear_exclusive_tag_i,
  input wire logic data_memory_barrier_i, data_sync_barrier_i, exception_taken_i,
  input wire logic bus_done_i, req_ready_o, resp_valid_o, resp_fault_o, resp_excl_fail_o,
  input wire logic barrier_done_o, exec_hold_o, bus_valid_o, bus_write_o, bus_lock_o,
  input wire logic [1:0] bus_size_o,
  input wire logic [31:0] bus_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic tv, aw, pend, spend;
  logic [31:0] ta;
  wire tk = req_valid_i && req_ready_o;
  wire sa = req_addr_i >= SRAM_ALIAS_BASE && req_addr_i <= SRAM_ALIAS_LAST;
  wire pa = req_addr_i >= PERI_ALIAS_BASE && req_addr_i <= PERI_ALIAS_LAST;
  wire tag_ok = tv && ta == req_addr_i;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {tv, aw, pend, spend, ta} <= '0;
    end else begin
      if (clear_exclusive_tag_i || exception_taken_i || tk && req_store_excl_i) tv <= 1'b0;
      // a load taken with a drop in the same cycle keeps its tag
      if (tk && req_load_excl_i) begin
        tv <= 1'b1;
        ta <= req_addr_i;
      end
      if (tk) aw <= (sa || pa) && req_write_i && !req_fetch_i;
      pend <= (pend || data_memory_barrier_i || data_sync_barrier_i) && !barrier_done_o;
      spend <= (spend || data_sync_barrier_i) && !barrier_done_o;
    end
  end
  AST_PERI_FETCH: assert property (tk && req_fetch_i && pa |=> resp_fault_o && !bus_valid_o)
    else $error("peri alias fetch not refused");
  AST_HOLE_FAULT: assert property (tk && req_addr_i > SRAM_BAND_LAST && !sa && !pa &&
    req_addr_i < SRAM_ALIAS_BASE |=> resp_valid_o && resp_fault_o && !bus_valid_o)
    else $error("reserved access not faulted");
  AST_ALIAS_MAP: assert property (tk && sa && !(req_fetch_i | req_load_excl_i | req_store_excl_i) |=>
    bus_valid_o && !bus_write_o && bus_size_o == $past(req_size_i) &&
    bus_addr_o[31:2] == SRAM_BAND_BASE[31:2] + $past(req_addr_i[20:7]))
    else $error("alias address or size wrong");
  AST_RMW_LOCK: assert property (aw && bus_valid_o && !bus_write_o && bus_done_i |->
    bus_lock_o ##[1:2] (bus_valid_o && bus_write_o && bus_lock_o))
    else $error("alias write back not locked");
  AST_EXCL_FAIL: assert property (tk && req_store_excl_i && !tag_ok |=>
    resp_valid_o && resp_excl_fail_o && !bus_valid_o)
    else $error("exclusive store without tag");
  AST_EXCL_PASS: assert property (tk && req_store_excl_i && tag_ok |=> bus_valid_o && bus_write_o)
    else $error("exclusive store with tag not written");
  AST_BAR_BLOCK: assert property (pend && !barrier_done_o |-> !req_ready_o)
    else $error("request taken during barrier");
  AST_SYNC_HOLD: assert property (spend && !barrier_done_o |-> exec_hold_o)
    else $error("execution not held in sync barrier");
  cover property (aw && resp_valid_o);
  cover property (tk && req_store_excl_i && !tag_ok);
  cover property (spend && barrier_done_o);
endmodule
bind bbx_unit bbx_unit_monitor mon (.*);
`default_nettype wire

/* File: testbench/test_bitband_exclusive_access_unit.sv */
// self-checking bench for the bit-band and exclusive access unit
`timescale 1ns/10ps
`default_nettype none
module test_bitband_exclusive_access_unit;
  import bbx_pkg::*;
  logic clk_i, arst_n_i, req_valid_i, req_write_i, req_fetch_i, req_load_excl_i, req_store_excl_i;
  logic clear_exclusive_tag_i, data_memory_barrier_i, data_sync_barrier_i, exception_taken_i;
  logic bus_done_i, bus_wr_posted_i, slow, fl, xf;
  logic bus_err_i = 1'b0;
  logic [1:0] req_size_i, bus_size_o;
  logic [31:0] req_addr_i, req_wdata_i, bus_rdata_i, resp_rdata_o, bus_addr_o, bus_wdata_o, rd;
  logic req_ready_o, resp_valid_o, resp_fault_o, resp_excl_fail_o, barrier_done_o, exec_hold_o;
  logic bus_valid_o, bus_write_o, bus_lock_o;
  int mismatches = 0, total_checks = 0, cycles = 0;
  bbx_unit dut (.*);
  bbx_bus_model bus (.clk_i(clk_i), .valid_i(bus_valid_o), .write_i(bus_write_o), .slow_i(slow),
    .addr_i(bus_addr_o), .wdata_i(bus_wdata_o), .done_o(bus_done_i), .rdata_o(bus_rdata_i));
  always #25 clk_i = ~clk_i;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // k: 0 plain, 1 fetch, 2 exclusive load, 3 exclusive store
  task automatic go(input logic [31:0] a, d, input logic w, input logic [1:0] s, input int k);
    logic r;
    req_valid_i <= 1'b1;
    req_addr_i <= a;
    req_wdata_i <= d;
    req_write_i <= w;
    req_size_i <= s;
    {req_fetch_i, req_load_excl_i, req_store_excl_i} <= {k == 1, k == 2, k == 3};
    // ready is sampled off the edge, the request stands through the edge that takes it
    do begin
      @(negedge clk_i);
      r = req_ready_o;
      @(posedge clk_i);
    end while (r !== 1'b1);
    req_valid_i <= 1'b0;
    do @(negedge clk_i); while (resp_valid_o !== 1'b1);
    {rd, fl, xf} = {resp_rdata_o, resp_fault_o, resp_excl_fail_o};
    @(posedge clk_i);
  endtask
  task automatic t_alias;
    go(32'h2000_0004, 32'h1234_5678, 1'b1, 2'h2, 0);
    go(32'h2200_008c, 32'hffff_fffe, 1'b1, 2'h2, 0);
    go(32'h2200_008c, 32'h0, 1'b0, 2'h2, 0);
    chk("alias read clear", ALIAS_READ_CLR, rd);
    go(32'h2200_0080, 32'h0000_0001, 1'b1, 2'h2, 0);
    go(32'h2200_0080, 32'h0, 1'b0, 2'h2, 0);
    chk("alias read set", ALIAS_READ_SET, rd);
    go(32'h2000_0004, 32'h0, 1'b0, 2'h2, 0);
    chk("band word", 32'h1234_5678 & ~32'h8 | 32'h1, rd);
    go(32'h4000_0000, 32'h0, 1'b1, 2'h2, 0);
    // byte 3 bit 7 sits in the top lane of the word
    go(32'h4200_007c, 32'hffff_ffff, 1'b1, 2'h2, 0);
    go(32'h4000_0000, 32'h0, 1'b0, 2'h2, 0);
    chk("peri band word", 32'h8000_0000, rd);
  endtask
  task automatic t_fault;
    go(32'h2001_0000, 32'h0, 1'b0, 2'h2, 0);
    chk("hole read", 32'h1, fl);
    go(32'h2220_0000, 32'h1, 1'b1, 2'h2, 0);
    chk("hole write", 32'h1, fl);
    go(32'h4200_0000, 32'h0, 1'b0, 2'h2, 1);
    chk("peri alias fetch", 32'h1, fl);
    go(32'h2200_0000, 32'h0, 1'b0, 2'h2, 1);
    chk("sram alias fetch", ~32'h2200_0000, rd);
    bus_err_i <= 1'b1;
    go(32'h6000_0000, 32'h0, 1'b0, 2'h2, 0);
    chk("fabric error", 32'h1, fl);
    bus_err_i <= 1'b0;
  endtask
  task automatic t_excl;
    for (int s = 0; s < 3; s++) begin
      go(32'h2000_0010, 32'h0, 1'b0, s[1:0], 2);
      go(32'h2000_0010, 32'h5, 1'b1, s[1:0], 3);
      chk("excl store status", 32'h0, xf);
    end
    go(32'h2000_0010, 32'h7, 1'b1, 2'h2, 3);
    chk("second excl store", 32'h1, xf);
    for (int i = 0; i < 2; i++) begin
      go(32'h2000_0010, 32'h0, 1'b0, 2'h2, 2);
      if (i == 0) clear_exclusive_tag_i <= 1'b1;
      else exception_taken_i <= 1'b1;
      @(posedge clk_i);
      {clear_exclusive_tag_i, exception_taken_i} <= 2'b00;
      go(32'h2000_0010, 32'h7, 1'b1, 2'h2, 3);
      chk("excl store after drop", 32'h1, xf);
      go(32'h2000_0010, 32'h0, 1'b0, 2'h2, 2);
      go(32'h2000_0010, 32'h5, 1'b1, 2'h2, 3);
      chk("retried excl store", 32'h0, xf);
    end
    go(32'h2000_0010, 32'h0, 1'b0, 2'h2, 0);
    chk("failed stores left memory", 32'h5, rd);
  endtask
  task automatic t_bar;
    for (int i = 0; i < 2; i++) begin
      bus_wr_posted_i <= 1'b1;
      {data_sync_barrier_i, data_memory_barrier_i} <= {i == 0, i == 1};
      @(posedge clk_i);
      {data_sync_barrier_i, data_memory_barrier_i} <= 2'b00;
      repeat (4) @(posedge clk_i);
      chk("ready while draining", 32'h0, req_ready_o);
      chk("exec hold", {31'h0, i == 0}, exec_hold_o);
      bus_wr_posted_i <= 1'b0;
      do @(negedge clk_i); while (barrier_done_o !== 1'b1);
      chk("hold released", 32'h0, exec_hold_o);
      chk("ready after drain", 32'h1, req_ready_o);
      @(posedge clk_i);
    end
  endtask
  initial begin
    clk_i = 1'b0;
    arst_n_i = 1'b0;
    {req_valid_i, req_write_i, req_fetch_i, req_load_excl_i, req_store_excl_i} = '0;
    {clear_exclusive_tag_i, data_memory_barrier_i, data_sync_barrier_i, exception_taken_i} = '0;
    {bus_wr_posted_i, slow, req_size_i, req_addr_i, req_wdata_i} = '0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    t_alias();
    t_fault();
    // slow bus answers for the exclusive pairs
    slow <= 1'b1;
    t_excl();
    t_bar();
    print_verdict();
  end
endmodule
`default_nettype wire
